// ---- core/acmp_core.sv ----
// Comparator event logic with debounce, APB register file and interrupt
// Assumes pclk at 10 MHz, synchronous inputs and a free-running timer 1 overflow pulse
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "acmp_map.svh"

module acmp_core (
    // APB slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Analog front end and timer
    input  wire acmp_pkg::acmp_front_s front,
    // Result and interrupts
    output logic                       compare_result,
    output logic                       cmp_irq_req,
    output logic                       irq
);
    import acmp_pkg::*;

    // ==========================================================
    // Registers
    logic [4:0]        ctrl_reg;
    logic [7:0]        ie_reg;
    acmp_power_s       power_reg;
    logic [1:0]        irq_status_reg;
    logic [1:0]        irq_mask_reg;
    logic [3:0]        phase_reg;
    logic              sample_reg;
    logic              prev_reg;
    logic              expect_reg;
    acmp_db_e          db_reg;
    logic              live;
    logic              s4_tick;
    logic              wr_en;
    logic              rd_en;
    logic              set_event;
    logic              set_discard;
    logic              flag_clr;
    logic              addr_ok;
    acmp_mode_e        mode;
    logic              wr_ctrl;
    logic              wr_ie;
    logic              wr_pwr;
    logic              wr_mask;
    logic              wr_stat;
    logic              event_ok;

    function automatic logic is_debounce(input acmp_mode_e m);
        return (m == ACMP_TOGGLE_DB) || (m == ACMP_RISE_DB) || (m == ACMP_FALL_DB);
    endfunction

    // Edge condition met by a transition from p to n under mode m
    function automatic logic edge_hit(input acmp_mode_e m, input logic p, input logic n);
        case (m)
            ACMP_RISE, ACMP_RISE_DB:     return !p && n;
            ACMP_FALL, ACMP_FALL_DB:     return p && !n;
            ACMP_TOGGLE, ACMP_TOGGLE_DB: return p != n;
            default:                     return 1'b0;
        endcase
    endfunction

    // Level condition of the two level modes at one sample
    function automatic logic level_hit(input acmp_mode_e m, input logic n);
        case (m)
            ACMP_LOW_LEVEL:  return !n;
            ACMP_HIGH_LEVEL: return n;
            default:         return 1'b0;
        endcase
    endfunction

    // One decode for the error response and the hole check
    function automatic logic addr_known(input logic [11:0] a);
        case (a)
            `ACMP_CTRL_STATUS_ADDR,
            `ACMP_IRQ_STATUS_ADDR,
            `ACMP_IRQ_MASK_ADDR,
            `ACMP_INT_ENABLE_ADDR,
            `ACMP_POWER_ADDR,
            `ACMP_RESULT_ADDR: return 1'b1;
            default:           return 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Bus decode
    assign mode    = acmp_mode_e'(ctrl_reg[`ACMP_MODE_HI:0]);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign addr_ok = addr_known(paddr);
    // Write strobes, one per register except the read-only result register
    assign wr_ctrl = wr_en && (paddr == `ACMP_CTRL_STATUS_ADDR);
    assign wr_ie   = wr_en && (paddr == `ACMP_INT_ENABLE_ADDR);
    assign wr_pwr  = wr_en && (paddr == `ACMP_POWER_ADDR);
    assign wr_mask = wr_en && (paddr == `ACMP_IRQ_MASK_ADDR);
    assign wr_stat = wr_en && (paddr == `ACMP_IRQ_STATUS_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    assign live = ctrl_reg[`ACMP_ENABLE_BIT] && !power_reg.idle && !power_reg.pdown;

    // ==========================================================
    // Machine cycle phase divider
    // tick at phase 6 of the 12 (state S4)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 4'h0;
        end else if (phase_reg == `ACMP_PHASES_PER_MC - 4'h1) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end
    assign s4_tick = (phase_reg == `ACMP_PHASE_S4);

    // ==========================================================
    // Sampling; a disabled comparator reads low
    // result forced low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= 1'b0;
            prev_reg   <= 1'b0;
        end else if (!live) begin
            sample_reg <= 1'b0;
            prev_reg   <= 1'b0;
        end else if (s4_tick) begin
            prev_reg   <= sample_reg;
            sample_reg <= front.pos_gt_neg;
        end
    end
    assign compare_result = sample_reg;

    // ==========================================================
    // Event detection and debounce
    // A new edge seen while waiting is ignored; the pending one decides.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_reg      <= ACMP_DB_IDLE;
            expect_reg  <= 1'b0;
            set_event   <= 1'b0;
            set_discard <= 1'b0;
        end else begin
            set_event   <= 1'b0;
            set_discard <= 1'b0;
            if (!live) begin
                db_reg <= ACMP_DB_IDLE;
            end else begin
                case (db_reg)
                    ACMP_DB_IDLE: begin
                        if (s4_tick) begin
                            if ((mode == ACMP_LOW_LEVEL) || (mode == ACMP_HIGH_LEVEL)) begin
                                set_event <= level_hit(mode, front.pos_gt_neg);
                            end else if (edge_hit(mode, sample_reg, front.pos_gt_neg)) begin
                                if (is_debounce(mode)) begin
                                    db_reg     <= ACMP_DB_WAIT1;
                                    expect_reg <= front.pos_gt_neg;
                                end else begin
                                    set_event <= 1'b1;
                                end
                            end
                        end
                    end
                    ACMP_DB_WAIT1: begin
                        if (front.timer1_ovf) begin
                            db_reg <= ACMP_DB_WAIT2;
                        end
                    end
                    ACMP_DB_WAIT2: begin
                        if (front.timer1_ovf) begin
                            db_reg <= ACMP_DB_IDLE;
                            if (front.pos_gt_neg == expect_reg) begin
                                set_event <= 1'b1;
                            end else begin
                                set_discard <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        db_reg <= ACMP_DB_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Control/status register
    assign flag_clr = wr_ctrl && !pwdata[`ACMP_FLAG_BIT];
    // An event pulse counts only while the enable bit still stands
    assign event_ok = set_event && ctrl_reg[`ACMP_ENABLE_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `ACMP_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg[`ACMP_ENABLE_BIT:0] <= pwdata[`ACMP_ENABLE_BIT:0];
            end
            if (event_ok) begin
                ctrl_reg[`ACMP_FLAG_BIT] <= 1'b1;
            end else if (flag_clr) begin
                ctrl_reg[`ACMP_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Interrupt enable and low-power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_reg    <= `ACMP_IE_RESET;
            power_reg <= '0;
        end else begin
            if (wr_ie) begin
                ie_reg <= pwdata[7:0];
            end
            if (wr_pwr) begin
                power_reg <= acmp_power_s'(pwdata[1:0]);
            end
        end
    end

    assign cmp_irq_req = ctrl_reg[`ACMP_FLAG_BIT] && ie_reg[`ACMP_CMP_IRQ_EN_BIT];

    // ==========================================================
    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= 2'b00;
        end else if (wr_mask) begin
            irq_mask_reg <= pwdata[1:0];
        end
    end

    // ==========================================================
    // Sticky interrupt status, write one to clear
    // Set wins, so an event in the clearing cycle is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'b00;
        end else begin
            if (event_ok) begin
                irq_status_reg[`ACMP_IRQ_EVENT_BIT] <= 1'b1;
            end else if (wr_stat && pwdata[`ACMP_IRQ_EVENT_BIT]) begin
                irq_status_reg[`ACMP_IRQ_EVENT_BIT] <= 1'b0;
            end
            if (set_discard) begin
                irq_status_reg[`ACMP_IRQ_DISCARD_BIT] <= 1'b1;
            end else if (wr_stat && pwdata[`ACMP_IRQ_DISCARD_BIT]) begin
                irq_status_reg[`ACMP_IRQ_DISCARD_BIT] <= 1'b0;
            end
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // Read data, registered on the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en && !penable) begin
            case (paddr)
                `ACMP_CTRL_STATUS_ADDR: prdata <= {27'h0, ctrl_reg};
                `ACMP_IRQ_STATUS_ADDR:  prdata <= {30'h0, irq_status_reg};
                `ACMP_IRQ_MASK_ADDR:    prdata <= {30'h0, irq_mask_reg};
                `ACMP_INT_ENABLE_ADDR:  prdata <= {24'h0, ie_reg};
                `ACMP_POWER_ADDR:       prdata <= {30'h0, power_reg};
                `ACMP_RESULT_ADDR:      prdata <= {28'h0, db_reg, prev_reg, sample_reg};
                default:                prdata <= 32'h0;
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- core/acmp_map.svh ----
// Offsets, field positions, reset values and timing counts of the comparator block
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef ACMP_MAP_SVH
`define ACMP_MAP_SVH

// ==========================================================
// Register offsets (byte addresses, except ACMP_CTRL_STATUS_OFS, a word index)
`define ACMP_CTRL_STATUS_OFS   12'h097
`define ACMP_CTRL_STATUS_ADDR  12'h25c
`define ACMP_IRQ_STATUS_ADDR   12'h000
`define ACMP_IRQ_MASK_ADDR     12'h004
`define ACMP_INT_ENABLE_ADDR   12'h008
`define ACMP_POWER_ADDR        12'h00c
`define ACMP_RESULT_ADDR       12'h010

// ==========================================================
// Field positions
`define ACMP_FLAG_BIT          4
`define ACMP_ENABLE_BIT        3
`define ACMP_MODE_HI           2
`define ACMP_CMP_IRQ_EN_BIT    6
`define ACMP_IDLE_BIT          0
`define ACMP_PDOWN_BIT         1
`define ACMP_IRQ_EVENT_BIT     0
`define ACMP_IRQ_DISCARD_BIT   1

// ==========================================================
// Reset values
`define ACMP_CTRL_RESET        5'h00
`define ACMP_IE_RESET          8'h00

// ==========================================================
// Timing: one machine cycle is twelve clock periods
`define ACMP_PHASES_PER_MC     4'hc
`define ACMP_PHASE_S4          4'h6
`define ACMP_SETTLE_NS         10000
`define ACMP_CLK_NS            100
`define ACMP_SETTLE_CYCLES     ((`ACMP_SETTLE_NS + `ACMP_CLK_NS - 1) / `ACMP_CLK_NS)

`endif

// ---- core/acmp_pkg.sv ----
// Types shared by the comparator block
// Assumes the map header is included by the design files
package acmp_pkg;

    // ==========================================================
    // Event mode encoding
    typedef enum logic [2:0] {
        ACMP_LOW_LEVEL   = 3'h0,
        ACMP_RISE        = 3'h1,
        ACMP_TOGGLE_DB   = 3'h2,
        ACMP_RISE_DB     = 3'h3,
        ACMP_FALL        = 3'h4,
        ACMP_TOGGLE      = 3'h5,
        ACMP_FALL_DB     = 3'h6,
        ACMP_HIGH_LEVEL  = 3'h7
    } acmp_mode_e;

    // ==========================================================
    // Debounce sequencer, Gray along idle -> wait1 -> wait2
    typedef enum logic [1:0] {
        ACMP_DB_IDLE  = 2'b00,
        ACMP_DB_WAIT1 = 2'b01,
        ACMP_DB_WAIT2 = 2'b11
    } acmp_db_e;

    // ==========================================================
    // Analog front end carrier
    typedef struct packed {
        logic pos_gt_neg;
        logic timer1_ovf;
    } acmp_front_s;

    // Low-power state of the processor
    typedef struct packed {
        logic pdown;
        logic idle;
    } acmp_power_s;

endpackage

// ---- verification/acmp_front_model.sv ----
// Far-side model: analog input pair and free-running timer 1
// Assumes clk is pclk and the inputs change just after rising edges
`timescale 1ns/1ns
`default_nettype none
module acmp_front_model #(
    parameter int OVF_PERIOD = 40
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Analog levels and result
    input  wire logic [7:0]           pos_in,
    input  wire logic [7:0]           neg_in,
    output var  acmp_pkg::acmp_front_s front
);
    import acmp_pkg::*;
    int cnt;
    // ====
    // Timer 1 never stops, so overflows keep coming
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cnt <= 0;
        else cnt <= (cnt == OVF_PERIOD - 1) ? 0 : cnt + 1;
    end
    assign front = '{pos_gt_neg: pos_in > neg_in, timer1_ovf: cnt == OVF_PERIOD - 1};
endmodule
`default_nettype wire

// ---- verification/acmp_core_props.sv ----
// Checker on the comparator block ports
// Assumes a bind into acmp_core and the map header on the include path
`timescale 1ns/1ns
`default_nettype none
`include "acmp_map.svh"
module acmp_core_props (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Comparator side
    input wire acmp_pkg::acmp_front_s front,
    input wire logic        compare_result,
    input wire logic        cmp_irq_req,
    input wire logic        irq
);
    import acmp_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc, wr, hit, ctl;
    logic [3:0] sh_reg;
    // ====
    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign ctl = paddr == `ACMP_CTRL_STATUS_ADDR;
    assign hit = ctl || paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    // Shadow of enable and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sh_reg <= 4'h0;
        else if (wr && ctl) sh_reg <= pwdata[3:0];
    end
    sequence s_off; wr && ctl && !pwdata[3]; endsequence
    sequence s_low; !compare_result [*2]; endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_slverr_bad: assert property (acc && !hit |-> pslverr) else $error("no error on hole");
    a_slverr_ok: assert property (acc && hit |-> !pslverr) else $error("error on register");
    a_hole_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0) else $error("hole read nonzero");
    a_ctrl_read: assert property (acc && !pwrite && ctl |-> prdata == {27'h0, prdata[4], sh_reg})
        else $error("control readback wrong");
    a_off_low: assert property (s_off |=> ##1 s_low) else $error("result high when off");
    a_flag_sticky: assert property ($fell(cmp_irq_req) |-> $past(wr)) else $error("flag fell alone");
    a_set_enabled: assert property ($rose(cmp_irq_req) && !$past(wr) |-> $past(sh_reg[3]))
        else $error("flag set while off");
    a_result_input: assert property ($rose(compare_result) |-> $past(front.pos_gt_neg))
        else $error("result without input");
endmodule
bind acmp_core acmp_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .front(front), .compare_result(compare_result), .cmp_irq_req(cmp_irq_req), .irq(irq));
`default_nettype wire

// ---- verification/acmp_core_tb.sv ----
// Self-checking bench for the comparator block
// Assumes design, checker and front model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "acmp_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module acmp_core_tb;
    import acmp_pkg::*;
    localparam logic [11:0] CTL = `ACMP_CTRL_STATUS_ADDR;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se, cres, creq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  pos, neg;
    acmp_front_s front;
    int          err_total, tests_run, cyc;
    acmp_front_model #(.OVF_PERIOD(40)) u_front (.clk(pclk), .rstn(presetn), .pos_in(pos), .neg_in(neg),
        .front(front));
    acmp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .front(front), .compare_result(cres), .cmp_irq_req(creq), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 12000) begin
            err_total++;
            summarize();
        end
    end
    // ====
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Random analog pair; equal values count as low
    task automatic drive(input logic hi);
        logic [7:0] b;
        b = 8'($urandom_range(0, 150));
        @(posedge pclk);
        pos <= hi ? b + 8'($urandom_range(1, 100)) : b;
        neg <= hi ? b : b + 8'($urandom_range(0, 100));
    endtask
    task automatic flag_is(input logic e);
        apb(1'b0, CTL, 32'h0);
        `CHK(q[4], e)
    endtask
    function automatic logic exp_rise(input logic [2:0] m); return m != 3'h4 && m != 3'h6; endfunction
    function automatic logic exp_fall(input logic [2:0] m); return m != 3'h1 && m != 3'h3; endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pos, neg} = '0;
        err_total = 0; tests_run = 0; cyc = 0; presetn = 1'b0;
        void'($urandom(88129));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTL, 32'h0); `CHK(q, 32'h0) // reset
        apb(1'b1, 12'h020, 32'h1); `CHK(se, 1'b1)
        apb(1'b0, 12'h020, 32'h0); `CHK(q, 32'h0)
        apb(1'b1, `ACMP_INT_ENABLE_ADDR, 32'h40);
        apb(1'b1, `ACMP_IRQ_MASK_ADDR, 32'h3);
        for (int m = 0; m < 8; m++) begin
            drive(1'b0);
            apb(1'b1, CTL, 32'h18 | 32'(m));
            idle(`ACMP_SETTLE_CYCLES); // settle first
            apb(1'b1, CTL, 32'h08 | 32'(m));
            idle(30); flag_is(m == 0); // low level
            drive(1'b1); idle(130); flag_is(exp_rise(3'(m)));
            `CHK(cres, 1'b1) // high result
            apb(1'b1, CTL, 32'h08 | 32'(m));
            idle(30); flag_is(m == 7);
            drive(1'b0); idle(130); flag_is(exp_fall(3'(m)));
        end
        `CHK(creq, 1'b1) // enabled
        `CHK(irq, 1'b1)
        apb(1'b1, `ACMP_IRQ_MASK_ADDR, 32'h0); idle(1); `CHK(irq, 1'b0)
        apb(1'b1, `ACMP_IRQ_MASK_ADDR, 32'h3); apb(1'b1, `ACMP_IRQ_STATUS_ADDR, 32'h3);
        idle(1); `CHK(irq, 1'b0)
        apb(1'b1, `ACMP_INT_ENABLE_ADDR, 32'h0); idle(1); `CHK(creq, 1'b0) // gated
        // Short glitch in debounced rise mode
        apb(1'b1, CTL, 32'h0b); idle(30);
        drive(1'b1); idle(13); drive(1'b0); idle(130); flag_is(1'b0); // discard
        apb(1'b0, `ACMP_IRQ_STATUS_ADDR, 32'h0); `CHK(q[1], 1'b1) // recorded
        apb(1'b1, CTL, 32'h01); drive(1'b1); idle(40); flag_is(1'b0); // off
        `CHK(cres, 1'b0) // forced low
        for (int p = 1; p < 3; p++) begin
            drive(1'b0); apb(1'b1, CTL, 32'h09); idle(30);
            apb(1'b1, `ACMP_POWER_ADDR, 32'(p)); apb(1'b1, CTL, 32'h09);
            drive(1'b1); idle(40); flag_is(1'b0); // low power
            `CHK(cres, 1'b0) // result off
            apb(1'b1, `ACMP_POWER_ADDR, 32'h0);
        end
        summarize();
    end
endmodule
`default_nettype wire
